// File: stimseq_regs.svh
// Register map, field layout and limits of the stimulus vector sequencer
`ifndef STIMSEQ_REGS_SVH
`define STIMSEQ_REGS_SVH

`define VEC_DATA_W 48
`define HALF_W 24
`define PTR_W 24
`define VEC_W 53
`define OP_LSB 48
`define OP_MSB 49
`define WSEL_LSB 50
`define WSEL_MSB 52
`define OP_ARM 2'h1
`define OP_WAIT 2'h2
`define N_COND 4
`define COND_W 8

`define A_CTRL 8'h00
`define A_CLK 8'h04
`define A_STRB 8'h08
`define A_COND_HI 4'h1
`define A_MAIN 8'h20
`define A_LAST 8'h24
`define A_STAT 8'h28

`define C_START 0
`define C_STOP 1
`define C_REP 2
`define C_EXT 3

`define MHZ_MIN 9'h001
`define MHZ_MAX 9'h12C
`define MHZ_HALF 9'h0B4
`define MHZ_RST 9'h00A
`define STRB_MAX 4'hD
`define PATTERN_RECOG_NS 15

`endif

// File: stimseq_pkg.sv
// Types shared by the stimulus vector sequencer
`default_nettype none
package stimseq_pkg;
    typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} seq_state_e;

    typedef struct packed {
        logic rep;
        logic ext;
        logic [8:0] mhz;
        logic [3:0] step;
        logic [23:0] main;
        logic [23:0] last;
        logic [31:0] cond;
        logic start_tgl;
        logic stop_tgl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } regs_s;

    typedef struct packed {
        seq_state_e st;
        logic [23:0] ptr;
        logic [47:0] data;
        logic strobe;
        logic arm_out;
        logic start_seen;
        logic stop_seen;
        logic busy;
        logic waiting;
        logic rep;
        logic half;
        logic [23:0] main;
        logic [23:0] last;
        logic [31:0] cond;
    } seq_s;
endpackage
`default_nettype wire

// File: sync2.sv
// Two-flop synchroniser for levels and toggles
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // First stage is read only by the second
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// File: wait_match.sv
// Wait condition evaluation against the input pattern or the arm input
`include "stimseq_regs.svh"
`default_nettype none
module wait_match (
    input wire logic [2:0] pattern_i,
    input wire logic arm_i,
    input wire logic [`N_COND*`COND_W-1:0] cond_i,
    input wire logic [2:0] sel_i,
    output logic match_o
);
    logic [`N_COND-1:0] hit;

    // Each condition is an OR over the selected pattern values
    for (genvar i = 0; i < `N_COND; i++) begin : g_cond
        assign hit[i] = cond_i[i*`COND_W + int'(pattern_i)];
    end

    // Selectors 4 to 7 all mean the arm input
    assign match_o = sel_i[2] ? arm_i : hit[sel_i[1:0]];
endmodule
`default_nettype wire

// File: stimulus_vector_sequencer.sv
// Stimulus vector sequencer: APB registers and vector playback on the output clock
//
// Implementation choices: register access over APB and the placing of the registers.
`include "stimseq_regs.svh"
`default_nettype none
module stimulus_vector_sequencer (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic link_clk_i,
    output logic [`PTR_W-1:0] vec_addr_o,
    input wire logic [`VEC_W-1:0] vec_rdata_i,
    output logic [`VEC_DATA_W-1:0] data_o,
    output logic strobe_o,
    output logic arm_out_o,
    input wire logic [2:0] pattern_i,
    input wire logic arm_i,
    output logic clk_ext_sel_o,
    output logic [8:0] clk_mhz_o,
    output logic [3:0] strobe_step_o
);
    stimseq_pkg::regs_s r, next_r;
    stimseq_pkg::seq_s s, next_s;

    logic [1:0] stat_sync;
    logic [1:0] ctl_sync;
    logic [3:0] in_sync;
    logic half_now;
    logic wr_en;
    logic [8:0] wr_mhz;
    logic [3:0] wr_step;

    logic start_ev;
    logic stop_ev;
    logic [1:0] op;
    logic match;
    logic go;
    logic at_last;

    // ---------------- Register side, reference clock ----------------

    assign half_now = !r.ext && (r.mhz > `MHZ_HALF);
    assign wr_en = psel_i && penable_i && r.pready && pwrite_i;
    assign wr_mhz = pwdata_i[8:0];
    assign wr_step = pwdata_i[3:0];

    always_comb begin
        next_r = r;
        next_r.pready = psel_i && !penable_i;
        if (psel_i && !penable_i) begin
            next_r.prdata = '0;
            next_r.pslverr = 1'b0;
            if (paddr_i[7:4] == `A_COND_HI && paddr_i[1:0] == 2'h0) begin
                next_r.prdata[`COND_W-1:0] = r.cond[paddr_i[3:2]*`COND_W +: `COND_W];
            end else begin
                case (paddr_i)
                    `A_CTRL: begin
                        next_r.prdata[`C_REP] = r.rep;
                        next_r.prdata[`C_EXT] = r.ext;
                    end
                    `A_CLK: next_r.prdata[8:0] = r.mhz;
                    `A_STRB: next_r.prdata[3:0] = r.step;
                    `A_MAIN: next_r.prdata[`PTR_W-1:0] = r.main;
                    `A_LAST: next_r.prdata[`PTR_W-1:0] = r.last;
                    `A_STAT: next_r.prdata[2:0] = {half_now, stat_sync};
                    default: next_r.pslverr = 1'b1;
                endcase
            end
        end
        if (wr_en) begin
            if (paddr_i[7:4] == `A_COND_HI && paddr_i[1:0] == 2'h0) begin
                next_r.cond[paddr_i[3:2]*`COND_W +: `COND_W] = pwdata_i[`COND_W-1:0];
            end else begin
                case (paddr_i)
                    `A_CTRL: begin
                        next_r.rep = pwdata_i[`C_REP];
                        next_r.ext = pwdata_i[`C_EXT];
                        // Stop is taken before start when both are written
                        if (pwdata_i[`C_STOP]) begin
                            next_r.stop_tgl = !r.stop_tgl;
                        end
                        if (pwdata_i[`C_START]) begin
                            next_r.start_tgl = !r.start_tgl;
                        end
                    end
                    `A_CLK: begin
                        // Out-of-range rates clamp rather than fault
                        if (wr_mhz < `MHZ_MIN) begin
                            next_r.mhz = `MHZ_MIN;
                        end else if (wr_mhz > `MHZ_MAX) begin
                            next_r.mhz = `MHZ_MAX;
                        end else begin
                            next_r.mhz = wr_mhz;
                        end
                    end
                    `A_STRB: next_r.step = (wr_step > `STRB_MAX) ? `STRB_MAX : wr_step;
                    `A_MAIN: next_r.main = pwdata_i[`PTR_W-1:0];
                    `A_LAST: next_r.last = pwdata_i[`PTR_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.mhz <= `MHZ_RST;
        end else begin
            r <= next_r;
        end
    end

    assign prdata_o = r.prdata;
    assign pready_o = r.pready;
    assign pslverr_o = r.pslverr;
    assign clk_ext_sel_o = r.ext;
    assign clk_mhz_o = r.mhz;
    assign strobe_step_o = r.step;

    sync2 #(.WIDTH(2)) u_stat_sync (
        .clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .d_i({s.waiting, s.busy}),
        .q_o(stat_sync)
    );

    // ---------------- Playback side, output clock ----------------

    sync2 #(.WIDTH(2)) u_ctl_sync (
        .clk_i(link_clk_i),
        .resetn_i(resetn_i),
        .d_i({r.stop_tgl, r.start_tgl}),
        .q_o(ctl_sync)
    );

    // Level sensed, so a held pattern satisfies any number of waits
    sync2 #(.WIDTH(4)) u_in_sync (
        .clk_i(link_clk_i),
        .resetn_i(resetn_i),
        .d_i({arm_i, pattern_i}),
        .q_o(in_sync)
    );

    wait_match u_match (
        .pattern_i(in_sync[2:0]),
        .arm_i(in_sync[3]),
        .cond_i(s.cond),
        .sel_i(vec_rdata_i[`WSEL_MSB:`WSEL_LSB]),
        .match_o(match)
    );

    assign start_ev = ctl_sync[0] != s.start_seen;
    assign stop_ev = ctl_sync[1] != s.stop_seen;
    assign op = vec_rdata_i[`OP_MSB:`OP_LSB];
    assign at_last = s.ptr == s.last;
    assign go = (s.st == stimseq_pkg::S_RUN && (op != `OP_WAIT || match)) ||
                (s.st == stimseq_pkg::S_WAIT && match);

    always_comb begin
        next_s = s;
        next_s.start_seen = ctl_sync[0];
        next_s.stop_seen = ctl_sync[1];
        next_s.strobe = 1'b0;
        next_s.arm_out = 1'b0;
        case (s.st)
            stimseq_pkg::S_IDLE: ;
            stimseq_pkg::S_RUN, stimseq_pkg::S_WAIT: begin
                if (go) begin
                    // Upper half forced low in half-channel operation
                    next_s.data = s.half ? {{`HALF_W{1'b0}}, vec_rdata_i[`HALF_W-1:0]}
                                         : vec_rdata_i[`VEC_DATA_W-1:0];
                    next_s.strobe = 1'b1;
                    next_s.arm_out = op == `OP_ARM;
                    next_s.st = stimseq_pkg::S_RUN;
                    if (at_last) begin
                        if (s.rep) begin
                            next_s.ptr = s.main;
                        end else begin
                            next_s.st = stimseq_pkg::S_IDLE;
                        end
                    end else begin
                        next_s.ptr = s.ptr + 24'h000001;
                    end
                end else begin
                    next_s.st = stimseq_pkg::S_WAIT;
                end
            end
            default: next_s.st = stimseq_pkg::S_IDLE;
        endcase
        if (stop_ev) begin
            next_s.st = stimseq_pkg::S_IDLE;
        end
        // Settings are frozen at start; software keeps them still meanwhile
        if (start_ev) begin
            next_s.st = stimseq_pkg::S_RUN;
            next_s.ptr = '0;
            next_s.rep = r.rep;
            next_s.half = half_now;
            next_s.main = r.main;
            next_s.last = r.last;
            next_s.cond = r.cond;
        end
        next_s.busy = next_s.st != stimseq_pkg::S_IDLE;
        next_s.waiting = next_s.st == stimseq_pkg::S_WAIT;
    end

    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign vec_addr_o = s.ptr;
    assign data_o = s.data;
    assign strobe_o = s.strobe;
    assign arm_out_o = s.arm_out;

    // ---------------- Checks ----------------

    property p_idle_hold;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (s.st == stimseq_pkg::S_IDLE && !start_ev) |=> ($stable(data_o) && !strobe_o);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("data moved while idle");

    property p_strobe_edge;
        @(posedge link_clk_i) disable iff (!resetn_i)
        !$stable(data_o) |-> strobe_o;
    endproperty
    a_strobe_edge: assert property (p_strobe_edge) else $error("vector change without strobe");

    property p_arm_out;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (go && op == `OP_ARM && !stop_ev && !start_ev) |=>
            arm_out_o && strobe_o ##1 (!arm_out_o || $past(op) == `OP_ARM);
    endproperty
    a_arm_out: assert property (p_arm_out) else $error("arm-out not pulsed");

    property p_arm_cause;
        @(posedge link_clk_i) disable iff (!resetn_i)
        arm_out_o |-> $past(op) == `OP_ARM && strobe_o;
    endproperty
    a_arm_cause: assert property (p_arm_cause) else $error("spurious arm-out");

    property p_half;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (s.half && strobe_o) |-> data_o[`VEC_DATA_W-1:`HALF_W] == '0;
    endproperty
    a_half: assert property (p_half) else $error("upper channels driven in half mode");

    property p_wait_hold;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (s.st == stimseq_pkg::S_WAIT && !match && !start_ev && !stop_ev) |=>
            $stable(data_o) && !strobe_o && $stable(vec_addr_o);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("output moved during wait");

    property p_wrap;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (go && at_last && s.rep && !start_ev && !stop_ev) |=> vec_addr_o == $past(s.main) && s.busy;
    endproperty
    a_wrap: assert property (p_wrap) else $error("main section did not loop");

    property p_linear;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (go && !at_last && !start_ev && !stop_ev) |=> vec_addr_o == $past(vec_addr_o) + 24'h000001;
    endproperty
    a_linear: assert property (p_linear) else $error("pointer not linear");

    property p_cond;
        @(posedge link_clk_i) disable iff (!resetn_i)
        !vec_rdata_i[`WSEL_MSB] |->
            match == s.cond[vec_rdata_i[`WSEL_MSB-1:`WSEL_LSB]*`COND_W + in_sync[2:0]];
    endproperty
    a_cond: assert property (p_cond) else $error("wait condition mismatch");

    property p_step;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        strobe_step_o <= `STRB_MAX && clk_mhz_o >= `MHZ_MIN && clk_mhz_o <= `MHZ_MAX;
    endproperty
    a_step: assert property (p_step) else $error("strobe step or rate out of range");

    property p_start_ptr;
        @(posedge link_clk_i) disable iff (!resetn_i)
        start_ev |=> vec_addr_o == '0 && s.busy;
    endproperty
    a_start_ptr: assert property (p_start_ptr) else $error("run did not begin at first init vector");

    property p_stop_idle;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (stop_ev && !start_ev) |=> !s.busy;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not end the run");

    // Arm-select wait must resume on the first edge that sees the synced arm level
    property p_arm_resume;
        @(posedge link_clk_i) disable iff (!resetn_i)
        (s.st == stimseq_pkg::S_WAIT && vec_rdata_i[`WSEL_MSB] && in_sync[3] && !start_ev && !stop_ev) |=> strobe_o;
    endproperty
    a_arm_resume: assert property (p_arm_resume) else $error("output did not resume after arm");
endmodule
`default_nettype wire

// File: stimseq_mem_model.sv
// Vector memory model standing in for the far side of the playback port
`default_nettype none
module stimseq_mem_model (
    input wire logic [23:0] addr_i,
    output logic [52:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 4096;
    logic [52:0] mem [DEPTH];
    // Straight-line words only, no loop or call words
    assign rdata_o = mem[addr_i[11:0]];
endmodule
`default_nettype wire

// File: tb_stimulus_vector_sequencer.sv
// Self-checking bench for the stimulus vector sequencer
`include "stimseq_regs.svh"
`default_nettype none
module tb_stimulus_vector_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, resetn_i, link_clk_i, psel, penable, pwrite, arm, pready, pslverr, strobe, arm_out, ext_sel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic err_q;
    logic [`PTR_W-1:0] vec_addr;
    logic [`VEC_W-1:0] vec_rdata;
    logic [`VEC_DATA_W-1:0] data;
    logic [8:0] mhz;
    logic [3:0] step;
    logic [2:0] pattern;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [47:0] seen[$];
    logic arms[$];

    stimulus_vector_sequencer i_stimulus_vector_sequencer (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .link_clk_i(link_clk_i), .vec_addr_o(vec_addr), .vec_rdata_i(vec_rdata), .data_o(data),
        .strobe_o(strobe), .arm_out_o(arm_out), .pattern_i(pattern), .arm_i(arm), .clk_ext_sel_o(ext_sel),
        .clk_mhz_o(mhz), .strobe_step_o(step)
    );
    stimseq_mem_model i_stimseq_mem_model (.addr_i(vec_addr), .rdata_o(vec_rdata));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Odd start offset keeps the link edges unrelated to the register clock; high phase far above 2 ns
    initial begin
        link_clk_i = 1'b0;
        #37;
        forever #80 link_clk_i = ~link_clk_i;
    end

    always @(posedge link_clk_i) begin
        if (strobe === 1'b1) begin
            seen.push_back(data);
            arms.push_back(arm_out);
        end
    end

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    function automatic logic [47:0] vdat(int k);
        return {24'h5A5A5A ^ 24'(k), 24'h000111 + 24'(k)};
    endfunction

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(string name, logic [63:0] s, logic [63:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", name, e, s);
        end
    endtask

    task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(string n, logic [7:0] a, logic [31:0] e, logic eerr);
        apb(a, 1'b0, 32'h0);
        check(n, 64'(rd_q), 64'(e));
        check("pslverr", 64'(err_q), 64'(eerr));
    endtask

    task automatic put(int k, logic [1:0] op, logic [2:0] sel);
        i_stimseq_mem_model.mem[k] = {sel, op, vdat(k)};
    endtask

    task automatic link_wait(int n);
        repeat (n) @(posedge link_clk_i);
    endtask

    task automatic go(logic [31:0] ctrl, logic [31:0] main, logic [31:0] last);
        seen.delete();
        arms.delete();
        apb(`A_MAIN, 1'b1, main);
        apb(`A_LAST, 1'b1, last);
        apb(`A_CTRL, 1'b1, ctrl);
    endtask

    // Missing entries read as unknown, so a short capture fails too
    task automatic cmp_seq(int n, int main, int last, logic half);
        int idx;
        logic [47:0] e;
        for (int i = 0; i < n; i++) begin
            idx = (i <= last) ? i : main + (i - main) % (last - main + 1);
            e = vdat(idx);
            if (half) begin
                e[47:24] = 24'h0;
            end
            check("vector", 64'(seen[i]), 64'(e));
        end
    endtask

    task automatic t_reset();
        check("data_o", 64'(data), 64'h0);
        check("strobe_arm", 64'({strobe, arm_out}), 64'h0);
        rchk("ctrl", `A_CTRL, 32'h0, 1'b0);
        rchk("rate", `A_CLK, 32'(`MHZ_RST), 1'b0);
        rchk("status", `A_STAT, 32'h0, 1'b0);
    endtask

    task automatic t_regs();
        apb(`A_CLK, 1'b1, 32'h0);
        rchk("rate_min", `A_CLK, 32'h1, 1'b0);
        apb(`A_CLK, 1'b1, 32'h12D);
        rchk("rate_max", `A_CLK, 32'h12C, 1'b0);
        check("clk_mhz_o", 64'(mhz), 64'h12C);
        apb(`A_STRB, 1'b1, 32'hF);
        rchk("step", `A_STRB, 32'hD, 1'b0);
        check("strobe_step_o", 64'(step), 64'hD);
        rchk("unmapped", 8'h30, 32'h0, 1'b1);
        rchk("misaligned", 8'h02, 32'h0, 1'b1);
        apb(`A_LAST, 1'b1, 32'hFFFFFFFF);
        rchk("last", `A_LAST, 32'hFFFFFF, 1'b0);
        apb(`A_MAIN, 1'b1, 32'h00ABCDEF);
        rchk("main", `A_MAIN, 32'hABCDEF, 1'b0);
        apb(`A_CLK, 1'b1, 32'hB4);
        rchk("full_ch", `A_STAT, 32'h0, 1'b0);
        apb(`A_CLK, 1'b1, 32'hB5);
        rchk("half_ch", `A_STAT, 32'h4, 1'b0);
        apb(`A_CTRL, 1'b1, 32'h8);
        rchk("ext_ctrl", `A_CTRL, 32'h8, 1'b0);
        rchk("ext_full", `A_STAT, 32'h0, 1'b0);
        check("clk_ext_sel_o", 64'(ext_sel), 64'h1);
        apb(`A_CTRL, 1'b1, 32'h0);
        apb(`A_CLK, 1'b1, 32'hA);
    endtask

    task automatic t_once();
        put(2, `OP_ARM, 3'h0);
        go(32'h1, 32'h0, 32'h4);
        link_wait(12);
        check("count", 64'(seen.size()), 64'h5);
        cmp_seq(5, 0, 4, 1'b0);
        for (int i = 0; i < 5; i++) begin
            check("arm_out", 64'(arms[i]), 64'(i == 2));
        end
        check("hold", 64'(data), 64'(vdat(4)));
        check("ptr_hold", 64'(vec_addr), 64'h4);
        rchk("idle", `A_STAT, 32'h0, 1'b0);
        put(2, 2'h0, 3'h0);
    endtask

    task automatic t_repeat();
        go(32'h5, 32'h2, 32'h4);
        link_wait(20);
        apb(`A_CTRL, 1'b1, 32'h2);
        link_wait(4);
        cmp_seq(12, 2, 4, 1'b0);
        rchk("stopped", `A_STAT, 32'h0, 1'b0);
        apb(`A_CTRL, 1'b1, 32'h0);
    endtask

    task automatic t_half();
        apb(`A_CLK, 1'b1, 32'hB5);
        go(32'h1, 32'h0, 32'h2);
        link_wait(10);
        cmp_seq(3, 0, 2, 1'b1);
        apb(`A_CLK, 1'b1, 32'hA);
    endtask

    task automatic t_wait();
        for (int i = 0; i < 4; i++) begin
            apb(8'h10 + 8'(4 * i), 1'b1, 32'h11 << i);
            rchk("cond", 8'h10 + 8'(4 * i), 32'h11 << i, 1'b0);
        end
        put(1, `OP_WAIT, 3'h2);
        put(3, `OP_WAIT, 3'h5);
        go(32'h1, 32'h0, 32'h4);
        link_wait(15);
        check("stall_pat", 64'(seen.size()), 64'h1);
        rchk("waiting", `A_STAT, 32'h3, 1'b0);
        @(posedge ref_clk_i);
        pattern <= 3'h6;
        link_wait(6);
        check("pat_match", 64'(seen.size()), 64'h3);
        link_wait(8);
        check("stall_arm", 64'(seen.size()), 64'h3);
        @(posedge ref_clk_i);
        arm <= 1'b1;
        link_wait(8);
        cmp_seq(5, 0, 4, 1'b0);
        pattern <= 3'h0;
        arm <= 1'b0;
    endtask

    // Reset while stalled on a wait word must drop everything back to idle
    task automatic t_midreset();
        go(32'h5, 32'h0, 32'h4);
        link_wait(6);
        rchk("stalled", `A_STAT, 32'h3, 1'b0);
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        link_wait(2);
        @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        link_wait(3);
        check("rst_data", 64'(data), 64'h0);
        check("rst_ptr", 64'(vec_addr), 64'h0);
        check("rst_strobe_arm", 64'({strobe, arm_out}), 64'h0);
        rchk("rst_rate", `A_CLK, 32'(`MHZ_RST), 1'b0);
        rchk("rst_status", `A_STAT, 32'h0, 1'b0);
    endtask

    initial begin
        resetn_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pattern = 3'h0;
        arm = 1'b0;
        for (int k = 0; k < 4096; k++) begin
            put(k, 2'h0, 3'h0);
        end
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        // Link side synchronisers need a few of their own edges
        link_wait(3);
        t_reset();
        t_regs();
        t_once();
        t_repeat();
        t_half();
        t_wait();
        t_midreset();
        end_sim();
    end
endmodule
`default_nettype wire
